// ---- mech_cfg_pkg.sv ----
package mech_cfg_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int         ADDR_W       = 8;
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_ZERO_CNT = 8'h04;
    localparam logic [7:0] OFF_RANGE    = 8'h08;
    localparam logic [7:0] OFF_RATIO    = 8'h0c;
    localparam logic [7:0] OFF_OFFSET   = 8'h10;
    localparam logic [7:0] OFF_GEAR_DEN = 8'h14;
    localparam logic [7:0] OFF_GEAR_NUM = 8'h18;
    localparam logic [7:0] OFF_MECH     = 8'h1c;
    localparam logic [7:0] OFF_LEAD     = 8'h20;
    localparam logic [7:0] OFF_STATUS   = 8'h24;
    localparam logic [7:0] OFF_TARGET   = 8'h28;
    localparam logic [7:0] OFF_STEPS    = 8'h2c;
    localparam logic [7:0] OFF_OP       = 8'h30;
    localparam logic [7:0] OFF_POS      = 8'h34;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_COORD   = 0;
    localparam int CTRL_MECH    = 1;
    localparam int CTRL_WRAP    = 2;
    localparam int MECH_DIR     = 0;
    localparam int MECH_DEC_LSB = 16;
    localparam int ST_MECH      = 0;
    localparam int ST_WRAP      = 1;
    localparam int ST_REFUSED   = 2;
    localparam int ST_BUSY      = 3;

    // ------------------------------------------------------------
    // Values after reset and limits
    // ------------------------------------------------------------
    localparam logic [15:0] GEAR_RST     = 16'h0001;
    localparam logic        DIR_RST      = 1'b1;
    localparam logic        WRAP_EN_RST  = 1'b1;
    localparam logic [15:0] RANGE_RST    = 16'h000a;
    localparam logic [15:0] RATIO_RST    = 16'h1388;
    localparam logic [15:0] ZERO_CNT_RST = 16'h0001;
    localparam logic [15:0] LEAD_RST     = 16'h0001;
    localparam logic [1:0]  DEC_RST      = 2'h0;
    localparam logic [15:0] LEAD_MAX     = 16'h7fff;
    localparam logic [15:0] RATIO_MAX    = 16'h2710;
    localparam logic [15:0] RANGE_MIN    = 16'h0005;
    localparam logic [15:0] RANGE_MAX    = 16'h4650;

    // Steps per revolution at unity gear, range unit is 0.1 rev
    localparam int REV_STEPS  = 1000;
    localparam int RANGE_DIV  = 10;
    localparam int RATIO_FULL = 10000;
    localparam int DIV_STEPS  = 48;

    typedef enum logic [3:0] {
        OP_ABS         = 4'h0,
        OP_INC         = 4'h1,
        OP_W_ABS       = 4'h8,
        OP_W_NEAR      = 4'h9,
        OP_W_FWD       = 4'ha,
        OP_W_REV       = 4'hb,
        OP_W_PUSH      = 4'hc,
        OP_W_NEAR_PUSH = 4'hd,
        OP_W_FWD_PUSH  = 4'he,
        OP_W_REV_PUSH  = 4'hf
    } op_kind_type;

    typedef enum logic [1:0] {
        DIV_IDLE = 2'b00,
        DIV_RUN  = 2'b01,
        DIV_DONE = 2'b10
    } div_state_type;

endpackage

// ---- gear_if.sv ----
`timescale 1ns/10ps
interface gear_if;
    logic               start;
    logic signed [31:0] pos;
    logic [15:0]        num;
    logic [15:0]        den;
    logic               busy;
    logic               done;
    logic signed [31:0] steps;

    modport master (output start, pos, num, den,
                    input  busy, done, steps);
    modport scaler (input  start, pos, num, den,
                    output busy, done, steps);
endinterface

// ---- gear_scale.sv ----
`timescale 1ns/10ps
module gear_scale (
    input  wire logic clk,
    input  wire logic sys_rst,
    gear_if.scaler    g
);
    import mech_cfg_pkg::*;

    div_state_type      st_q;
    logic [5:0]         cnt_q;
    logic [47:0]        quo_q;
    logic [16:0]        rem_q;
    logic               neg_q;
    logic               done_q;
    logic signed [31:0] steps_q;

    wire [31:0] mag    = g.pos[31] ? 32'(-g.pos) : g.pos;
    wire [47:0] prod   = {16'h0, mag} * {32'h0, g.num};
    wire [16:0] rem_sh = {rem_q[15:0], quo_q[47]};
    wire        fit    = rem_sh >= {1'b0, g.den};
    wire [16:0] rem_nx = fit ? rem_sh - {1'b0, g.den} : rem_sh;
    // Quotients beyond the 32-bit step range saturate
    wire        sat    = |quo_q[47:31];
    wire [31:0] clip   = sat ? 32'h7fffffff : quo_q[31:0];

    assign g.busy  = st_q != DIV_IDLE;
    assign g.done  = done_q;
    assign g.steps = steps_q;

    // ------------------------------------------------------------
    // Restoring divider: |pos| * num / den, one bit a cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q    <= DIV_IDLE;
            cnt_q   <= 6'h0;
            quo_q   <= 48'h0;
            rem_q   <= 17'h0;
            neg_q   <= 1'b0;
            done_q  <= 1'b0;
            steps_q <= 32'sh0;
        end else begin
            case (st_q)
                DIV_IDLE: begin
                    done_q <= 1'b0;
                    if (g.start) begin
                        quo_q <= prod;
                        rem_q <= 17'h0;
                        cnt_q <= 6'h0;
                        neg_q <= g.pos[31];
                        st_q  <= DIV_RUN;
                    end
                end
                DIV_RUN: begin
                    quo_q <= {quo_q[46:0], fit};
                    rem_q <= rem_nx;
                    cnt_q <= cnt_q + 6'h1;
                    if (cnt_q == 6'(DIV_STEPS - 1))
                        st_q <= DIV_DONE;
                end
                DIV_DONE: begin
                    steps_q <= neg_q ? -$signed(clip) : $signed(clip);
                    done_q  <= 1'b1;
                    st_q    <= DIV_IDLE;
                end
                default: st_q <= DIV_IDLE;
            endcase
        end
    end

    a_scale_latency: assert property (
        @(posedge clk) disable iff (sys_rst)
        (g.start && st_q == DIV_IDLE) |-> ##50 g.done)
        else $error("gear result not ready 50 cycles after start");

endmodule

// ---- mech_gear_wrap_cfg.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// Operation
// - Wrap parameters writable only in manual coordinate mode
// - Sensor mechanism values govern unless manual selected
// - Mechanism selector change applies after power restart
// - Gear denominator accepts 1..65535, default 1
// - Gear numerator accepts 1..65535, default 1
// - Direction 0 counterclockwise, 1 clockwise, default 1
// - Screw lead 1..32767, tool only, no motion
// - Lead decimal selector 0..3, default 0, tool only
// - Wrap operations run only with wrap enabled
// - 100 rev, 50% ratio gives -50..+50 rev
// - Command position wraps after configured range
// ------------------------------------------------------------
module mech_gear_wrap_cfg (
    input  wire logic                              clk,
    input  wire logic                              sys_rst,
    input  wire logic [mech_cfg_pkg::ADDR_W-1:0]   paddr,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [31:0]                       pwdata,
    output wire logic [31:0]                       prdata,
    output wire logic                              pready,
    output wire logic                              pslverr,
    input  wire logic                              power_restart,
    input  wire logic [15:0]                       sens_gear_num,
    input  wire logic [15:0]                       sens_gear_den,
    input  wire logic                              sens_dir_cw,
    input  wire logic                              step_pulse,
    input  wire logic                              step_fwd,
    output wire logic                              motor_dir_cw,
    output wire logic                              wrap_active,
    output wire logic [31:0]                       cmd_pos,
    output wire logic                              revolution_zero_output,
    output wire logic                              op_start,
    output mech_cfg_pkg::op_kind_type              op_kind
);
    import mech_cfg_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic               coord_man_q;
    logic               mech_pend_q;
    logic               mech_act_q;
    logic               wrap_en_q;
    logic [15:0]        zero_cnt_q;
    logic [15:0]        range_q;
    logic [15:0]        ratio_q;
    logic signed [31:0] offset_q;
    logic [15:0]        gear_den_q;
    logic [15:0]        gear_num_q;
    logic               dir_q;
    logic [1:0]         dec_q;
    logic [15:0]        lead_q;
    logic signed [31:0] target_q;
    logic               start_q;
    logic               refused_q;
    logic               op_start_q;
    op_kind_type        op_kind_q;
    logic signed [31:0] cmd_pos_q;
    logic signed [31:0] pos_d;
    logic [31:0]        rel_q;
    logic [31:0]        rel_d;
    logic               rz_q;
    logic               dir_out_q;
    logic [31:0]        rd_q;

    gear_if gi ();

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire wr       = psel & penable & pwrite;
    wire rd_setup = psel & ~penable & ~pwrite;

    wire is_ctrl   = paddr == OFF_CTRL;
    wire is_zero   = paddr == OFF_ZERO_CNT;
    wire is_range  = paddr == OFF_RANGE;
    wire is_ratio  = paddr == OFF_RATIO;
    wire is_offset = paddr == OFF_OFFSET;
    wire is_den    = paddr == OFF_GEAR_DEN;
    wire is_num    = paddr == OFF_GEAR_NUM;
    wire is_mech   = paddr == OFF_MECH;
    wire is_lead   = paddr == OFF_LEAD;
    wire is_status = paddr == OFF_STATUS;
    wire is_target = paddr == OFF_TARGET;
    wire is_steps  = paddr == OFF_STEPS;
    wire is_op     = paddr == OFF_OP;
    wire is_pos    = paddr == OFF_POS;

    wire hit = is_ctrl | is_zero | is_range | is_ratio | is_offset |
               is_den | is_num | is_mech | is_lead | is_status |
               is_target | is_steps | is_op | is_pos;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata  = rd_q;

    // ------------------------------------------------------------
    // Write qualification
    // ------------------------------------------------------------
    wire w16      = pwdata[31:16] == 16'h0;
    wire lo_nz    = pwdata[15:0] != 16'h0;
    wire gear_ok  = w16 & lo_nz;
    wire range_ok = w16 & (pwdata[15:0] >= RANGE_MIN) &
                    (pwdata[15:0] <= RANGE_MAX);
    wire ratio_ok = w16 & (pwdata[15:0] <= RATIO_MAX);
    wire off_ok   = (pwdata[31:29] == 3'b000) |
                    (pwdata[31:29] == 3'b111);
    wire lead_ok  = gear_ok & (pwdata[15:0] <= LEAD_MAX);

    // Wrap fields freeze unless coordinates are under manual control
    wire wr_coord = wr & coord_man_q;
    wire wr_ctrl  = wr & is_ctrl;
    wire wr_zero  = wr_coord & is_zero & gear_ok;
    wire wr_range = wr_coord & is_range & range_ok;
    wire wr_ratio = wr_coord & is_ratio & ratio_ok;
    wire wr_off   = wr_coord & is_offset & off_ok;
    wire wr_den   = wr & is_den & gear_ok;
    wire wr_num   = wr & is_num & gear_ok;
    wire wr_mech  = wr & is_mech;
    wire wr_lead  = wr & is_lead & lead_ok;
    wire wr_op    = wr & is_op;

    wire busy_w   = gi.busy | start_q;
    wire start_d  = wr & is_target & ~busy_w;

    // Undefined operation codes are refused like a blocked wrap
    wire op_wrap  = pwdata[3];
    wire op_known = op_wrap | (pwdata[3:1] == 3'b000);
    wire op_ok    = op_known & (~op_wrap | wrap_active);

    // ------------------------------------------------------------
    // Effective mechanism values
    // ------------------------------------------------------------
    wire [15:0] gear_num_eff = mech_act_q ? gear_num_q : sens_gear_num;
    wire [15:0] gear_den_eff = mech_act_q ? gear_den_q : sens_gear_den;
    wire        dir_eff      = mech_act_q ? dir_q : sens_dir_cw;

    assign gi.start = start_q;
    assign gi.pos   = target_q;
    assign gi.num   = gear_num_eff;
    // A zero from the sensor would stall nothing but give garbage
    assign gi.den   = (gear_den_eff == 16'h0) ? GEAR_RST : gear_den_eff;

    // ------------------------------------------------------------
    // Wrap coordinate span
    // ------------------------------------------------------------
    wire [31:0] span_w = 32'(({16'h0, range_q} * 32'(REV_STEPS)) /
                             32'(RANGE_DIV));
    wire [63:0] shift_w = ({32'h0, span_w} * {48'h0, ratio_q}) /
                          64'(RATIO_FULL);
    wire signed [31:0] low_w = offset_q - $signed(shift_w[31:0]);
    wire signed [31:0] hi_w  = low_w + $signed(span_w) - 32'sd1;
    wire [31:0] seg_w = span_w / {16'h0, zero_cnt_q};

    assign wrap_active = coord_man_q & wrap_en_q;

    wire at_hi    = cmd_pos_q == hi_w;
    wire at_lo    = cmd_pos_q == low_w;
    wire wrap_fwd = wrap_active & step_fwd & at_hi;
    wire wrap_rev = wrap_active & ~step_fwd & at_lo;
    wire seg_end  = rel_q == seg_w - 32'h1;
    wire seg_beg  = rel_q == 32'h0;

    // Position returns to the opposite end of the span once it is covered
    assign pos_d = ~step_pulse ? cmd_pos_q :
                   wrap_fwd    ? low_w :
                   wrap_rev    ? hi_w :
                   step_fwd    ? cmd_pos_q + 32'sd1 :
                                 cmd_pos_q - 32'sd1;

    // Segment counter is not realigned when wrap fields change
    assign rel_d = ~step_pulse           ? rel_q :
                   step_fwd & (wrap_fwd | seg_end) ? 32'h0 :
                   step_fwd              ? rel_q + 32'h1 :
                   (wrap_rev | seg_beg)  ? seg_w - 32'h1 :
                                           rel_q - 32'h1;

    wire rz_d = step_pulse & wrap_active & (rel_d == 32'h0);

    assign cmd_pos                = cmd_pos_q;
    assign revolution_zero_output = rz_q;
    assign motor_dir_cw           = dir_out_q;
    assign op_start               = op_start_q;
    assign op_kind                = op_kind_q;

    // ------------------------------------------------------------
    // Read selection
    // ------------------------------------------------------------
    wire [31:0] ctrl_rd = {29'h0, wrap_en_q, mech_pend_q, coord_man_q};
    wire [31:0] mech_rd = {14'h0, dec_q, 15'h0, dir_q};
    wire [31:0] stat_rd = {28'h0, busy_w, refused_q,
                           wrap_active, mech_act_q};

    wire [31:0] rd_mux =
        is_ctrl   ? ctrl_rd :
        is_zero   ? {16'h0, zero_cnt_q} :
        is_range  ? {16'h0, range_q} :
        is_ratio  ? {16'h0, ratio_q} :
        is_offset ? offset_q :
        is_den    ? {16'h0, gear_den_q} :
        is_num    ? {16'h0, gear_num_q} :
        is_mech   ? mech_rd :
        is_lead   ? {16'h0, lead_q} :
        is_status ? stat_rd :
        is_target ? target_q :
        is_steps  ? gi.steps :
        is_op     ? {28'h0, op_kind_q} :
        is_pos    ? cmd_pos_q :
                    32'h0;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            coord_man_q <= 1'b0;
            mech_pend_q <= 1'b0;
            wrap_en_q   <= WRAP_EN_RST;
        end else if (wr_ctrl) begin
            coord_man_q <= pwdata[CTRL_COORD];
            mech_pend_q <= pwdata[CTRL_MECH];
            if (coord_man_q)
                wrap_en_q <= pwdata[CTRL_WRAP];
        end
    end

    // Selector is latched into effect only by a power restart
    always_ff @(posedge clk) begin
        if (sys_rst)
            mech_act_q <= 1'b0;
        else if (power_restart)
            mech_act_q <= mech_pend_q;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            zero_cnt_q <= ZERO_CNT_RST;
            range_q    <= RANGE_RST;
            ratio_q    <= RATIO_RST;
            offset_q   <= 32'sh0;
        end else begin
            if (wr_zero)
                zero_cnt_q <= pwdata[15:0];
            if (wr_range)
                range_q <= pwdata[15:0];
            if (wr_ratio)
                ratio_q <= pwdata[15:0];
            if (wr_off)
                offset_q <= pwdata;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gear_den_q <= GEAR_RST;
            gear_num_q <= GEAR_RST;
        end else begin
            if (wr_den)
                gear_den_q <= pwdata[15:0];
            if (wr_num)
                gear_num_q <= pwdata[15:0];
        end
    end

    // Lead fields only serve host-side unit conversion
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dir_q  <= DIR_RST;
            dec_q  <= DEC_RST;
            lead_q <= LEAD_RST;
        end else begin
            if (wr_mech) begin
                dir_q <= pwdata[MECH_DIR];
                dec_q <= pwdata[MECH_DEC_LSB+1:MECH_DEC_LSB];
            end
            if (wr_lead)
                lead_q <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // Commands, motion tracking, read data
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            target_q   <= 32'sh0;
            start_q    <= 1'b0;
            refused_q  <= 1'b0;
            op_start_q <= 1'b0;
            op_kind_q  <= OP_ABS;
        end else begin
            start_q    <= start_d;
            op_start_q <= wr_op & op_ok;
            if (start_d)
                target_q <= pwdata;
            if (wr_op)
                refused_q <= ~op_ok;
            if (wr_op & op_ok)
                op_kind_q <= op_kind_type'(pwdata[3:0]);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmd_pos_q <= 32'sh0;
            rel_q     <= 32'h0;
            rz_q      <= 1'b0;
            dir_out_q <= DIR_RST;
            rd_q      <= 32'h0;
        end else begin
            cmd_pos_q <= pos_d;
            rel_q     <= rel_d;
            rz_q      <= rz_d;
            dir_out_q <= dir_eff;
            if (rd_setup)
                rd_q <= rd_mux;
        end
    end

    gear_scale u_scale (
        .clk     (clk),
        .sys_rst (sys_rst),
        .g       (gi.scaler)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_coord_gate_hold: assert property (
        (wr && is_range && !coord_man_q) |=> $stable(range_q))
        else $error("wrap range changed in sensor mode");

    a_sensor_dir_used: assert property (
        (!sys_rst && !mech_act_q && !power_restart) |=>
        motor_dir_cw == $past(sens_dir_cw))
        else $error("direction not taken from sensor");

    a_mech_restart_only: assert property (
        !power_restart |=> $stable(mech_act_q))
        else $error("mechanism source changed without restart");

    a_gear_den_range: assert property (
        (wr && is_den && !gear_ok) |=> $stable(gear_den_q))
        else $error("out of range denominator accepted");

    a_gear_num_nonzero: assert property (
        gear_num_q != 16'h0 && $past(gear_num_q) != 16'h0)
        else $error("numerator reached zero");

    a_manual_dir_used: assert property (
        (mech_act_q && !power_restart && !wr_mech) ##1 1'b1 |=>
        motor_dir_cw == $past(dir_q, 2))
        else $error("direction not taken from register");

    a_lead_in_range: assert property (
        lead_q != 16'h0 && lead_q <= LEAD_MAX)
        else $error("lead outside 1..32767");

    a_dec_write_only: assert property (
        !wr_mech |=> $stable(dec_q))
        else $error("decimal selector changed without write");

    a_wrap_op_block: assert property (
        (wr_op && pwdata[3] && !wrap_active) |=>
        (!op_start && refused_q))
        else $error("wrap operation started with wrap disabled");

    a_span_half: assert property (
        (range_q == 16'd1000 && ratio_q == 16'd5000 &&
         offset_q == 32'sh0) |->
        (low_w == -32'sd50000 && hi_w == 32'sd49999))
        else $error("100 rev half offset span wrong");

    a_wrap_return: assert property (
        (step_pulse && step_fwd && wrap_active && at_hi) |=>
        cmd_pos == $past(low_w))
        else $error("position did not wrap to span start");

    c_wrap_fwd:   cover property (step_pulse && wrap_fwd);
    c_op_refused: cover property (wr_op && !op_ok);
    c_restart:    cover property (power_restart && mech_pend_q);
    c_scale_done: cover property (gi.done);

endmodule

// ---- motor_model.sv ----
`timescale 1ns/10ps
module motor_model (
    input  wire logic        clk,
    input  wire logic        run,
    input  wire logic        fwd,
    output logic [15:0] sens_gear_num,
    output logic [15:0] sens_gear_den,
    output logic        sens_dir_cw,
    output logic        step_pulse,
    output logic        step_fwd
);
    // Sensor-stored mechanism, differs from the register defaults
    assign sens_gear_num = 16'h0002;
    assign sens_gear_den = 16'h0001;
    assign sens_dir_cw   = 1'b0;
    // Direction shows the inverse while idle so a stale value is never trusted
    always_ff @(posedge clk) begin
        step_pulse <= run;
        step_fwd   <= run ? fwd : ~fwd;
    end
endmodule

// ---- mechanism_gear_wrap_config_tb.sv ----
`timescale 1ns/10ps
`define CHK(a, e) check(32'(a), 32'(e))
module mechanism_gear_wrap_config_tb;
    import mech_cfg_pkg::*;
    logic        clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv, cmd_pos;
    logic        pready, pslverr, err, power_restart = 0, run = 0, fwd = 1;
    logic [15:0] sens_gear_num, sens_gear_den;
    logic        sens_dir_cw, step_pulse, step_fwd, motor_dir_cw;
    logic        wrap_active, revolution_zero_output, op_start;
    op_kind_type op_kind;
    int          failures = 0, total_checks = 0, rz_n = 0, op_n = 0;

    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (op_start === 1'b1) op_n++;
        if (revolution_zero_output === 1'b1) rz_n++;
    end

    mech_gear_wrap_cfg dut (.clk, .sys_rst, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .power_restart, .sens_gear_num,
        .sens_gear_den, .sens_dir_cw, .step_pulse, .step_fwd, .motor_dir_cw,
        .wrap_active, .cmd_pos, .revolution_zero_output, .op_start, .op_kind);
    motor_model motor (.clk, .run, .fwd, .sens_gear_num, .sens_gear_den,
        .sens_dir_cw, .step_pulse, .step_fwd);

    task automatic check(input logic [31:0] a, input logic [31:0] e);
        total_checks++;
        if (a !== e) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, a, e);
        end
    endtask

    // One idle cycle after each transfer keeps drivers off a shared step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) failures++;
        rv  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic done(input string s);
        $display("test %s finished, failures %0d", s, failures);
    endtask

    task automatic results;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        apb(0, OFF_GEAR_DEN, 0);
        `CHK(rv, 1);
        apb(0, OFF_GEAR_NUM, 0);
        `CHK(rv, 1);
        apb(0, OFF_MECH, 0);
        `CHK(rv, 1);
        `CHK(motor_dir_cw, 0);
        apb(1, 8'hfc, 32'h1);
        `CHK(err, 1);
        done("reset");
    endtask

    task automatic t_limits;
        apb(1, OFF_GEAR_DEN, 0);
        apb(0, OFF_GEAR_DEN, 0);
        `CHK(rv, 1);
        apb(1, OFF_GEAR_NUM, 32'hffff);
        apb(0, OFF_GEAR_NUM, 0);
        `CHK(rv, 32'hffff);
        apb(1, OFF_LEAD, 32'h8000);
        apb(0, OFF_LEAD, 0);
        `CHK(rv, 1);
        apb(1, OFF_MECH, 32'h0003_0001);
        apb(0, OFF_MECH, 0);
        `CHK(rv, 32'h0003_0001);
        apb(1, OFF_TARGET, 32'h7);
        repeat (60) @(posedge clk);
        apb(0, OFF_STEPS, 0);
        `CHK(rv, 32'he);
        done("limits");
    endtask

    task automatic t_mech;
        apb(1, OFF_CTRL, 32'h2);
        repeat (2) @(posedge clk);
        `CHK(motor_dir_cw, 0);
        power_restart <= 1'b1;
        @(posedge clk);
        power_restart <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(motor_dir_cw, 1);
        apb(1, OFF_MECH, 32'h0);
        repeat (2) @(posedge clk);
        `CHK(motor_dir_cw, 0);
        apb(1, OFF_GEAR_NUM, 32'h3);
        apb(1, OFF_GEAR_DEN, 32'h2);
        apb(1, OFF_TARGET, 32'hffff_fff9);
        repeat (60) @(posedge clk);
        apb(0, OFF_STEPS, 0);
        `CHK(rv, 32'hffff_fff6);
        done("mechanism");
    endtask

    task automatic t_wrap;
        apb(1, OFF_OP, 32'h8);
        apb(0, OFF_STATUS, 0);
        `CHK(rv[2], 1);
        `CHK(wrap_active, 0);
        apb(1, OFF_RANGE, 32'h5);
        apb(0, OFF_RANGE, 0);
        `CHK(rv, 32'ha);
        apb(1, OFF_CTRL, 32'h7);
        `CHK(wrap_active, 1);
        apb(1, OFF_RANGE, 32'h5);
        apb(0, OFF_RANGE, 0);
        `CHK(rv, 32'h5);
        for (int k = 8; k < 16; k++) apb(1, OFF_OP, 32'(k));
        repeat (2) @(posedge clk);
        `CHK(op_n, 8);
        `CHK(op_kind, OP_W_REV_PUSH);
        run <= 1'b1;
        repeat (250) @(posedge clk);
        run <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(cmd_pos, 32'hffff_ff06);
        `CHK(rz_n, 1);
        apb(1, OFF_RANGE, 32'h3e8);
        apb(0, OFF_RANGE, 0);
        `CHK(rv, 32'h3e8);
        done("wrap");
    endtask

    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset;
        t_limits;
        t_mech;
        t_wrap;
        results;
    end

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        results;
    end
endmodule
